// ==== src/twpc_pkg.sv ====
// Constants for the timer, watchdog and prescaler control.
// Assumes a 250 MHz instruction-cycle clock.
package twpc_pkg;

	// Control word field positions
	localparam int CW_PULL_N = 7;
	localparam int CW_INT_EN = 6;
	localparam int CW_PSC_SEL = 3;
	localparam int CW_RATIO_LO = 0;
	// Watchdog/sleep control field positions
	localparam int WS_OPEN_DRAIN = 6;
	localparam int WS_WDT_EN = 5;
	localparam int WS_OSC_RUN = 4;
	localparam int WS_ROPT_EN = 3;
	localparam int WS_WAKE_N = 0;
	// Interrupt flag and mask positions
	localparam int IRQ_TIMER1 = 3;
	localparam int IRQ_SERIAL = 2;
	localparam int IRQ_EXT = 1;
	localparam int IRQ_OVF = 0;

	// Writable bits of each register
	localparam logic [7:0] CW_WR_MASK = 8'h8F;
	localparam logic [7:0] WS_WR_MASK = 8'h79;
	localparam logic [7:0] IM_WR_MASK = 8'h0F;

	// Reset values
	localparam logic [7:0] CW_RST = 8'h80;
	localparam logic [7:0] WS_RST = 8'h11;
	localparam logic [7:0] IM_RST = 8'h00;
	localparam logic [7:0] TIMER_RST = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;

	// Timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int WDT_TIMEOUT_US = 18000;
	localparam int WDT_BASE_CYC = (WDT_TIMEOUT_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int OST_CYC = 64;

endpackage

// ==== src/twpc_psc_if.sv ====
// Link between the control logic and the shared prescaler.
// Assumes both ends on the same clock.
`timescale 1ns/1ns
interface twpc_psc_if;
	logic clr; // Clear count
	logic inc; // Count one source event
	logic to_wdt; // Assigned to watchdog
	logic [2:0] ratio; // Ratio code
	logic tick; // Period complete

	modport ctl (output clr, output inc, output to_wdt, output ratio, input tick);
	modport psc (input clr, input inc, input to_wdt, input ratio, output tick);
endinterface

// ==== src/twpc_prescaler.sv ====
// Shared 8-bit prescaler, serving timer or watchdog.
// Assumes clear and increment come from the same clock domain.
`timescale 1ns/1ns
module twpc_prescaler
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Control side
	twpc_psc_if.psc p
);

	logic [7:0] count; // Prescaler count
	logic [7:0] mask; // Low bits that must be all ones

	// Ratio decode: timer 1:2..1:256, watchdog 1:1..1:128
	always_comb
	begin
		if (p.to_wdt)
		begin
			mask = 8'((9'h001 << p.ratio) - 9'h001);
		end
		else
		begin
			mask = 8'((9'h002 << p.ratio) - 9'h001);
		end
	end

	// Period ends on the increment made while the masked bits are all ones
	assign p.tick = p.inc && !p.clr && ((count & mask) == mask);

	// One counter, cleared or advanced
	always_ff @(posedge mclk_i)
	begin
		if (srst_i || p.clr)
		begin
			count <= 8'h00;
		end
		else if (p.inc)
		begin
			count <= count + 8'h01;
		end
	end

endmodule

// ==== src/twpc_top.sv ====
// Timer/counter, watchdog, shared prescaler and their control registers.
// Assumes instruction strobes are one-cycle pulses on mclk_i.
//
// What this block does
// - Select bit routes prescaler to timer or watchdog.
// - One 8-bit prescaler counter serves either user.
// - Ratio codes double, timer from 2, watchdog 1.
// - Timer write clears prescaler when timer owns it.
// - Watchdog clear or sleep clears watchdog, prescaler when watchdog owns it.
// - Timer steps each cycle or per prescaler period.
// - Enabled watchdog time-out resets device, sleep too.
// - Watchdog enable bit works only with fuse set.
// - Base time-out about 18 ms, times prescaler.
// - Control bit 7 low enables pull-ups.
// - Bit 6 set/cleared by interrupt instructions only.
// - Bits 5,4 read zero; bits 7, 3..0 read/write.
// - Wake falling edge sets oscillator run bit.
// - Wake while asleep or oscillator stopped starts start-up timer first.
// - Wake enable bit low lets pins wake.
// - Open-drain bit switches two pins to open-drain.
// - Resistor option bit enables reading strap pins.
// - Mask bits enable timer1, serial, external, overflow.
// - Overflow sets flag; software only clears it.
// - Status read is flags AND mask.
`timescale 1ns/1ns
module twpc_top
#(
	parameter int WDT_BASE_CYC = twpc_pkg::WDT_BASE_CYC, // Base time-out in cycles
	parameter int OST_CYC = twpc_pkg::OST_CYC // Start-up timer length
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Register write instructions
	input wire logic [7:0] wr_data_i,
	input wire logic control_word_write_instr_i,
	input wire logic watchdog_sleep_wr_i,
	input wire logic interrupt_mask_wr_i,
	input wire logic timer_counter_wr_i,
	input wire logic interrupt_status_wr_i,
	// Special instructions
	input wire logic interrupt_enable_instr_i,
	input wire logic interrupt_disable_instr_i,
	input wire logic return_from_interrupt_instr_i,
	input wire logic watchdog_clear_instr_i,
	input wire logic sleep_instr_i,
	// Interrupt source events
	input wire logic timer1_evt_i,
	input wire logic serial_evt_i,
	input wire logic external_evt_i,
	// Pins and fuse
	input wire logic wake_n_i,
	input wire logic [1:0] ropt_pin_i,
	input wire logic watchdog_option_i,
	// Register read values
	output logic [7:0] prescale_interrupt_control_o,
	output logic [7:0] watchdog_sleep_control_o,
	output logic [7:0] interrupt_mask_o,
	output logic [7:0] interrupt_status_o,
	output logic [7:0] timer_counter_o,
	// Control outputs
	output logic pull_high_global_n_o,
	output logic open_drain_select_o,
	output logic wake_enable_n_o,
	output logic resistor_option_enable_o,
	output logic [1:0] ropt_status_o,
	output logic global_int_enable_o,
	// Power and reset outputs
	output logic oscillator_run_o,
	output logic deep_sleep_o,
	output logic sleep_o,
	output logic startup_busy_o,
	output logic watchdog_active_o,
	output logic watchdog_reset_o
);

	// Prescaler link
	twpc_psc_if psc_if();

	// Control word pieces
	logic pull_high_global_n; // Bit 7, active low
	logic int_en; // Bit 6
	logic prescaler_select; // Bit 3, 1 = watchdog
	logic [2:0] prescale_ratio; // Bits 2..0

	// Watchdog/sleep pieces
	logic open_drain_select; // Bit 6
	logic watchdog_enable; // Bit 5
	logic oscillator_run; // Bit 4
	logic resistor_option_enable; // Bit 3
	logic wake_enable_n; // Bit 0

	// Mask, flags, timer
	logic [3:0] irq_mask; // Interrupt enables
	logic [3:0] irq_flags; // Pending flags
	logic [7:0] timer_counter; // Timer/counter value

	// Watchdog and sleep state
	logic [22:0] wdt_base; // Base period counter
	logic sleeping; // Sleep instruction state
	logic [15:0] ost_cnt; // Start-up timer count

	// Synchronisers
	logic [1:0] wake_sync; // Wake pin, stage 1 and 2
	logic wake_prev; // Previous synced wake level
	logic [1:0] ropt_s1; // Strap pins stage 1
	logic [1:0] ropt_s2; // Strap pins stage 2
	logic [1:0] fuse_sync; // Fuse level stages

	// Derived terms
	logic fuse; // Synced watchdog option fuse
	logic wdt_on; // Watchdog really enabled
	logic wdt_clear; // Watchdog clear request
	logic base_evt; // Base period elapsed
	logic wdt_timeout; // Watchdog time-out
	logic wake_evt; // Accepted wake edge
	logic timer_step; // Timer increments
	logic timer_run; // Instruction cycles running
	logic ovf; // Timer wraps this cycle

	// Two-flop synchronisers for pins and fuse
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			wake_sync <= 2'b11;
			wake_prev <= 1'b1;
			ropt_s1 <= 2'b00;
			ropt_s2 <= 2'b00;
			fuse_sync <= 2'b00;
		end
		else
		begin
			wake_sync <= {wake_sync[0], wake_n_i};
			wake_prev <= wake_sync[1];
			ropt_s1 <= ropt_pin_i;
			ropt_s2 <= ropt_s1;
			fuse_sync <= {fuse_sync[0], watchdog_option_i};
		end
	end

	// Fuse gates the enable bit
	assign fuse = fuse_sync[1];
	assign wdt_on = fuse && watchdog_enable;

	// Wake edge counts only while pin wake-up is enabled
	assign wake_evt = wake_prev && !wake_sync[1] && !wake_enable_n;

	// Timer runs while the oscillator is up, not asleep and start-up timer done
	assign timer_run = oscillator_run && !sleeping && (ost_cnt == 16'h0000);

	// Prescaler routing
	assign psc_if.to_wdt = prescaler_select;
	assign psc_if.ratio = prescale_ratio;
	assign wdt_clear = watchdog_clear_instr_i || sleep_instr_i;
	// Clear on timer write or watchdog clear, by owner
	always_comb
	begin
		if (prescaler_select)
		begin
			psc_if.clr = wdt_clear;
			psc_if.inc = base_evt;
		end
		else
		begin
			psc_if.clr = timer_counter_wr_i;
			psc_if.inc = timer_run;
		end
	end

	// Shared prescaler
	twpc_prescaler u_psc
	(
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.p(psc_if.psc)
	);

	// Step timer directly or on prescaler tick
	assign timer_step = prescaler_select ? timer_run : psc_if.tick;
	// All ones plus one is the overflow
	assign ovf = timer_step && !timer_counter_wr_i && (timer_counter == 8'hFF);

	// Base period ends after the 18 ms count
	assign base_evt = wdt_on && !wdt_clear && (wdt_base == 23'(WDT_BASE_CYC - 1));
	// Time-out: base period, or prescaler tick when assigned
	assign wdt_timeout = prescaler_select ? psc_if.tick : base_evt;

	// Control word register
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			pull_high_global_n <= twpc_pkg::CW_RST[twpc_pkg::CW_PULL_N];
			prescaler_select <= twpc_pkg::CW_RST[twpc_pkg::CW_PSC_SEL];
			prescale_ratio <= twpc_pkg::CW_RST[2:0];
		end
		else if (control_word_write_instr_i)
		begin
			// Bit 6 left alone by this write
			pull_high_global_n <= wr_data_i[twpc_pkg::CW_PULL_N];
			prescaler_select <= wr_data_i[twpc_pkg::CW_PSC_SEL];
			prescale_ratio <= wr_data_i[twpc_pkg::CW_RATIO_LO +: 3];
		end
	end

	// Global interrupt enable, instructions only
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			int_en <= twpc_pkg::CW_RST[twpc_pkg::CW_INT_EN];
		end
		else if (interrupt_disable_instr_i)
		begin
			int_en <= 1'b0;
		end
		else if (interrupt_enable_instr_i || return_from_interrupt_instr_i)
		begin
			int_en <= 1'b1;
		end
	end

	// Watchdog/sleep control register
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			open_drain_select <= twpc_pkg::WS_RST[twpc_pkg::WS_OPEN_DRAIN];
			watchdog_enable <= twpc_pkg::WS_RST[twpc_pkg::WS_WDT_EN];
			resistor_option_enable <= twpc_pkg::WS_RST[twpc_pkg::WS_ROPT_EN];
			wake_enable_n <= twpc_pkg::WS_RST[twpc_pkg::WS_WAKE_N];
		end
		else if (watchdog_sleep_wr_i)
		begin
			open_drain_select <= wr_data_i[twpc_pkg::WS_OPEN_DRAIN];
			// Wake-up set wins over a same-cycle software clear
			watchdog_enable <= wr_data_i[twpc_pkg::WS_WDT_EN] | (wake_evt && fuse);
			resistor_option_enable <= wr_data_i[twpc_pkg::WS_ROPT_EN];
			wake_enable_n <= wr_data_i[twpc_pkg::WS_WAKE_N];
		end
		else if (wake_evt && fuse)
		begin
			// Woken device comes back with watchdog on
			watchdog_enable <= 1'b1;
		end
	end

	// Oscillator run bit: hardware set wins over software clear
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			oscillator_run <= twpc_pkg::WS_RST[twpc_pkg::WS_OSC_RUN];
		end
		else if (wake_evt)
		begin
			oscillator_run <= 1'b1;
		end
		else if (watchdog_sleep_wr_i)
		begin
			// Writing zero stops the oscillator
			oscillator_run <= wr_data_i[twpc_pkg::WS_OSC_RUN];
		end
	end

	// Sleep state from the sleep instruction
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			sleeping <= 1'b0;
		end
		else if (wake_evt)
		begin
			sleeping <= 1'b0;
		end
		else if (sleep_instr_i)
		begin
			sleeping <= 1'b1;
		end
	end

	// Start-up timer, loaded by a wake while asleep or oscillator stopped
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			ost_cnt <= 16'h0000;
		end
		else if (wake_evt && (sleeping || !oscillator_run))
		begin
			ost_cnt <= 16'(OST_CYC);
		end
		else if (ost_cnt != 16'h0000)
		begin
			ost_cnt <= ost_cnt - 16'h0001;
		end
	end

	// Interrupt mask register
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			irq_mask <= twpc_pkg::IM_RST[3:0];
		end
		else if (interrupt_mask_wr_i)
		begin
			irq_mask <= wr_data_i[3:0] & twpc_pkg::IM_WR_MASK[3:0];
		end
	end

	// Timer/counter: write wins, else step and wrap
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			timer_counter <= twpc_pkg::TIMER_RST;
		end
		else if (timer_counter_wr_i)
		begin
			timer_counter <= wr_data_i;
		end
		else if (timer_step)
		begin
			timer_counter <= timer_counter + 8'h01;
		end
	end

	// Pending flags: set beats clear, writes only clear
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			irq_flags <= twpc_pkg::FLAGS_RST;
		end
		else
		begin
			irq_flags <= (interrupt_status_wr_i ? (irq_flags & wr_data_i[3:0]) : irq_flags)
				| {timer1_evt_i, serial_evt_i, external_evt_i, ovf};
		end
	end

	// Watchdog base counter, counts through sleep
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			wdt_base <= 23'h00_0000;
		end
		else if (!wdt_on || wdt_clear || base_evt)
		begin
			wdt_base <= 23'h00_0000;
		end
		else
		begin
			wdt_base <= wdt_base + 23'h00_0001;
		end
	end

	// Time-out pulse resets device, asleep or not
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			watchdog_reset_o <= 1'b0;
			watchdog_active_o <= 1'b0;
		end
		else
		begin
			watchdog_reset_o <= wdt_on && wdt_timeout;
			watchdog_active_o <= wdt_on;
		end
	end

	// Registered register read values
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			prescale_interrupt_control_o <= twpc_pkg::CW_RST;
			watchdog_sleep_control_o <= twpc_pkg::WS_RST;
			interrupt_mask_o <= twpc_pkg::IM_RST;
			interrupt_status_o <= 8'h00;
			timer_counter_o <= twpc_pkg::TIMER_RST;
		end
		else
		begin
			// Control word bits 5 and 4 always zero
			prescale_interrupt_control_o <= {pull_high_global_n, int_en, 2'b00,
				prescaler_select, prescale_ratio};
			watchdog_sleep_control_o <= {1'b0, open_drain_select, watchdog_enable,
				oscillator_run, resistor_option_enable, 2'b00, wake_enable_n};
			interrupt_mask_o <= {4'h0, irq_mask};
			interrupt_status_o <= {4'h0, irq_flags & irq_mask};
			timer_counter_o <= timer_counter;
		end
	end

	// Pin controls and sleep status
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			pull_high_global_n_o <= twpc_pkg::CW_RST[twpc_pkg::CW_PULL_N];
			open_drain_select_o <= twpc_pkg::WS_RST[twpc_pkg::WS_OPEN_DRAIN];
			wake_enable_n_o <= twpc_pkg::WS_RST[twpc_pkg::WS_WAKE_N];
			resistor_option_enable_o <= twpc_pkg::WS_RST[twpc_pkg::WS_ROPT_EN];
			ropt_status_o <= 2'b00;
			global_int_enable_o <= twpc_pkg::CW_RST[twpc_pkg::CW_INT_EN];
			oscillator_run_o <= twpc_pkg::WS_RST[twpc_pkg::WS_OSC_RUN];
			deep_sleep_o <= ~twpc_pkg::WS_RST[twpc_pkg::WS_OSC_RUN];
			sleep_o <= 1'b0;
			startup_busy_o <= 1'b0;
		end
		else
		begin
			pull_high_global_n_o <= pull_high_global_n;
			open_drain_select_o <= open_drain_select;
			wake_enable_n_o <= wake_enable_n;
			resistor_option_enable_o <= resistor_option_enable;
			// Strap status only visible when enabled
			ropt_status_o <= resistor_option_enable ? ropt_s2 : 2'b00;
			global_int_enable_o <= int_en;
			oscillator_run_o <= oscillator_run;
			deep_sleep_o <= !oscillator_run;
			sleep_o <= sleeping;
			startup_busy_o <= (ost_cnt != 16'h0000);
		end
	end

endmodule

// ==== tb/twpc_checker.sv ====
// Assertion checker for twpc_top, bound to its ports.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ns
module twpc_checker
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Inputs watched
	input wire logic [7:0] wr_data_i,
	input wire logic timer_counter_wr_i,
	input wire logic interrupt_enable_instr_i,
	input wire logic interrupt_disable_instr_i,
	input wire logic return_from_interrupt_instr_i,
	// Outputs watched
	input wire logic [7:0] prescale_interrupt_control_o,
	input wire logic [7:0] interrupt_mask_o,
	input wire logic [7:0] interrupt_status_o,
	input wire logic [7:0] timer_counter_o,
	input wire logic [1:0] ropt_status_o,
	input wire logic resistor_option_enable_o,
	input wire logic global_int_enable_o,
	input wire logic oscillator_run_o,
	input wire logic deep_sleep_o,
	input wire logic watchdog_reset_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// Either instruction that enables interrupts
	logic ie_any;
	assign ie_any = interrupt_enable_instr_i | return_from_interrupt_instr_i;

	AST_CW_UNUSED: assert property (prescale_interrupt_control_o[5:4] == 2'b00)
		else $error("control word bits 5,4 not zero");
	AST_IE_OFF: assert property (interrupt_disable_instr_i |-> ##2 !global_int_enable_o)
		else $error("disable did not clear interrupt enable");
	AST_IE_ON: assert property (ie_any && !interrupt_disable_instr_i |-> ##2 global_int_enable_o)
		else $error("enable did not set interrupt enable");
	AST_IE_HOLD: assert property ($changed(global_int_enable_o) |-> $past(ie_any | interrupt_disable_instr_i, 2))
		else $error("interrupt enable changed without instruction");
	AST_STATUS_AND: assert property ((interrupt_status_o & ~interrupt_mask_o) == 8'h00)
		else $error("status shows a masked flag");
	AST_TMR_LOAD: assert property (timer_counter_wr_i |-> ##2 timer_counter_o == $past(wr_data_i, 2))
		else $error("timer write not loaded");
	AST_WRAP: assert property ($past(timer_counter_o) == 8'hFF && timer_counter_o == 8'h00
		&& interrupt_mask_o[0] |-> ##[0:2] interrupt_status_o[0]) else $error("wrap did not set flag");
	AST_DEEP: assert property (deep_sleep_o == !oscillator_run_o)
		else $error("deep sleep not inverse of oscillator run");
	AST_ROPT: assert property (!resistor_option_enable_o |-> ropt_status_o == 2'b00)
		else $error("strap status shown while disabled");
	AST_WDT_PULSE: assert property (watchdog_reset_o |=> !watchdog_reset_o)
		else $error("watchdog reset longer than one cycle");
	// Main scenarios reached
	cover property (watchdog_reset_o);
	cover property ($rose(oscillator_run_o));
	cover property ($rose(interrupt_status_o[0]));
endmodule

bind twpc_top twpc_checker u_chk (.mclk_i, .srst_i, .wr_data_i, .timer_counter_wr_i, .interrupt_enable_instr_i,
	.interrupt_disable_instr_i, .return_from_interrupt_instr_i, .prescale_interrupt_control_o, .interrupt_mask_o,
	.interrupt_status_o, .timer_counter_o, .ropt_status_o, .resistor_option_enable_o, .global_int_enable_o,
	.oscillator_run_o, .deep_sleep_o, .watchdog_reset_o);

// ==== tb/tb_top.sv ====
// Self-checking testbench for twpc_top, ports driven directly.
// Assumes shortened watchdog base and start-up counts.
`timescale 1ns/1ns
module tb_top;
	localparam int BASE = 20; // Short watchdog base
	localparam int OSCILLATOR_STARTUP_TIMER = 4; // Short start-up time
	// Strobe masks
	localparam logic [12:0] CW = 13'h0001, WS = 13'h0002, IM = 13'h0004, TM = 13'h0008, SW = 13'h0010;
	localparam logic [12:0] IE = 13'h0020, DI = 13'h0040, RI = 13'h0080, WC = 13'h0100, SL = 13'h0200;
	localparam logic [12:0] EV = 13'h1C00;
	logic mclk_i = 1'b0, srst_i = 1'b1, wake_n_i = 1'b1, watchdog_option_i = 1'b0;
	logic [7:0] wr_data_i = 8'h00;
	logic [1:0] ropt_pin_i = 2'b10;
	logic [12:0] st = 13'h0000; // Strobes and events
	logic [7:0] prescale_interrupt_control_o, watchdog_sleep_control_o, interrupt_mask_o;
	logic [7:0] interrupt_status_o, timer_counter_o;
	logic [1:0] ropt_status_o;
	logic pull_high_global_n_o, open_drain_select_o, wake_enable_n_o, resistor_option_enable_o;
	logic global_int_enable_o, oscillator_run_o, deep_sleep_o, sleep_o, startup_busy_o;
	logic watchdog_active_o, watchdog_reset_o;
	int mismatches = 0, n_tests = 0, n_rst = 0;

	twpc_top #(.WDT_BASE_CYC(BASE), .OST_CYC(OSCILLATOR_STARTUP_TIMER)) dut (.mclk_i, .srst_i, .wr_data_i,
		.control_word_write_instr_i(st[0]), .watchdog_sleep_wr_i(st[1]), .interrupt_mask_wr_i(st[2]),
		.timer_counter_wr_i(st[3]), .interrupt_status_wr_i(st[4]), .interrupt_enable_instr_i(st[5]),
		.interrupt_disable_instr_i(st[6]), .return_from_interrupt_instr_i(st[7]),
		.watchdog_clear_instr_i(st[8]), .sleep_instr_i(st[9]), .timer1_evt_i(st[10]),
		.serial_evt_i(st[11]), .external_evt_i(st[12]), .wake_n_i, .ropt_pin_i, .watchdog_option_i,
		.prescale_interrupt_control_o, .watchdog_sleep_control_o, .interrupt_mask_o, .interrupt_status_o,
		.timer_counter_o, .pull_high_global_n_o, .open_drain_select_o, .wake_enable_n_o,
		.resistor_option_enable_o, .ropt_status_o, .global_int_enable_o, .oscillator_run_o,
		.deep_sleep_o, .sleep_o, .startup_busy_o, .watchdog_active_o, .watchdog_reset_o);

	// Clock and watchdog pulse counter
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
		if (watchdog_reset_o === 1'b1)
			n_rst++;

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task bound(input int k, input int lim);
		if (k >= lim)
		begin
			mismatches++;
			end_of_test;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// One-cycle strobe, then wait until outputs show it
	task pulse(input logic [12:0] m, input logic [7:0] d);
		@(posedge mclk_i);
		st <= m;
		wr_data_i <= d;
		@(posedge mclk_i);
		st <= 13'h0000;
		cyc(2);
	endtask
	task t_reset;
		chk(prescale_interrupt_control_o, 8'h80);
		chk(watchdog_sleep_control_o, 8'h11);
		chk(interrupt_mask_o, 8'h00);
		chk(interrupt_status_o, 8'h00);
	endtask
	task t_cw;
		pulse(CW, 8'hFF);
		chk(prescale_interrupt_control_o, 8'h8F);
		chk({7'h00, pull_high_global_n_o}, 8'h01);
		pulse(CW, 8'h00);
		chk({7'h00, pull_high_global_n_o}, 8'h00);
	endtask
	task t_ie;
		logic [12:0] m [5];
		logic [7:0] e [5];
		m = '{IE, CW, DI, RI, DI | IE};
		e = '{8'h40, 8'h40, 8'h00, 8'h40, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			pulse(m[i], 8'h00);
			chk(prescale_interrupt_control_o, e[i]);
			chk({7'h00, global_int_enable_o}, {7'h00, e[i][6]});
		end
	endtask
	task t_ws;
		pulse(WS, 8'hFF);
		chk(watchdog_sleep_control_o, 8'h79);
		chk({4'h0, open_drain_select_o, wake_enable_n_o, resistor_option_enable_o, watchdog_active_o}, 8'h0E);
		chk({6'h00, ropt_status_o}, 8'h02);
		pulse(WS, 8'h10);
		chk({6'h00, open_drain_select_o, wake_enable_n_o}, 8'h00);
		chk({6'h00, ropt_status_o}, 8'h00);
	endtask
	task t_irq;
		pulse(IM, 8'hFF);
		chk(interrupt_mask_o, 8'h0F);
		pulse(IM, 8'h0E);
		pulse(EV, 8'h00);
		chk(interrupt_status_o, 8'h0E);
		pulse(IM, 8'h02);
		chk(interrupt_status_o, 8'h02);
		pulse(IM, 8'h0E);
		pulse(SW, 8'hF9);
		chk(interrupt_status_o, 8'h08);
		pulse(SW, 8'hFF);
		chk(interrupt_status_o, 8'h08);
	endtask
	// Timer rate for every ratio code, then wrap
	task t_tmr;
		logic [7:0] a;
		for (int r = 0; r < 8; r++)
		begin
			pulse(CW, 8'(r));
			pulse(TM, 8'h00);
			// Cleared prescaler puts the first step exactly one period after the write
			cyc((2 << r) - 2);
			chk(timer_counter_o, 8'h00);
			cyc(1);
			chk(timer_counter_o, 8'h01);
			cyc(3 * (2 << r));
			chk(timer_counter_o, 8'h04);
		end
		pulse(CW, 8'h08);
		a = timer_counter_o;
		cyc(8);
		chk(timer_counter_o - a, 8'h08);
		pulse(IM, 8'h01);
		pulse(TM, 8'h80);
		pulse(SW, 8'h00);
		pulse(TM, 8'hFD);
		cyc(4);
		chk(interrupt_status_o, 8'h01);
		chk({7'h00, timer_counter_o < 8'h10}, 8'h01);
	endtask
	// Cycles from a watchdog clear to the reset pulse
	task wdt_time(output int k);
		n_rst = 0;
		pulse(WC, 8'h00);
		k = 2;
		while (n_rst == 0 && k < 200)
		begin
			cyc(1);
			k++;
		end
		bound(k, 200);
	endtask
	task t_wdt;
		int k;
		@(posedge mclk_i);
		watchdog_option_i <= 1'b1;
		pulse(CW, 8'h00);
		pulse(WC, 8'h00);
		pulse(WS, 8'h31);
		chk({7'h00, watchdog_active_o}, 8'h01);
		n_rst = 0;
		for (int i = 0; i < 10; i++)
		begin
			pulse(WC, 8'h00);
			cyc(8);
		end
		chk(n_rst[7:0], 8'h00);
		wdt_time(k);
		chk({7'h00, k >= BASE && k <= BASE + 4}, 8'h01);
		pulse(CW, 8'h09);
		pulse(WS, 8'h31);
		wdt_time(k);
		chk({7'h00, k >= 2 * BASE && k <= 2 * BASE + 4}, 8'h01);
		pulse(WS, 8'h10);
	endtask
	// Stop oscillator, wake by pin, time start-up
	task t_sleep;
		int k;
		int b;
		pulse(SL, 8'h00);
		chk({7'h00, sleep_o}, 8'h01);
		pulse(WS, 8'h00);
		chk({6'h00, deep_sleep_o, oscillator_run_o}, 8'h02);
		@(posedge mclk_i);
		wake_n_i <= 1'b0;
		k = 0;
		b = 0;
		while (k < 40)
		begin
			cyc(1);
			k++;
			if (startup_busy_o === 1'b1)
				b++;
			else if (b > 0)
				break;
		end
		bound(k, 40);
		chk({7'h00, b >= OSCILLATOR_STARTUP_TIMER && b <= OSCILLATOR_STARTUP_TIMER + 1}, 8'h01);
		chk(watchdog_sleep_control_o, 8'h30);
		chk({6'h00, sleep_o, deep_sleep_o}, 8'h00);
		@(posedge mclk_i);
		wake_n_i <= 1'b1;
		pulse(WS, 8'h11);
	endtask

	initial
	begin
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		cyc(1);
		t_reset;
		t_cw;
		t_ie;
		t_ws;
		t_irq;
		t_tmr;
		t_wdt;
		t_sleep;
		end_of_test;
	end
endmodule
